/* rtl/p5m_cfg.svh */
// constants for the pin 5 output source multiplexer
//
// Contract
// - 8-bit control at 0x15, resets 0x00
// - source bits 4:2, 000-011 pick receive port
// - source 100 status, 110 transmit, others reserved
// - port select 000-011 drive forwarded pins 0-3
// - port select 100 lock, 101 pass
// - port select 110 frame valid, 111 line valid
// - status select 000 drives stored level bit
// - status select 001 ORs enabled port locks
// - status select 010 ANDs enabled port locks
// - status select 011 ANDs enabled port passes
// - transmit 000 ANDs, 001 ORs selected passes
// - transmit 010 frame active, 011 line active
// - transmit select 100 shows ports synchronized
// - transmit 101 interrupt, 110-111 reserved
// - bit 1 holds software output level
// - bit 0 enables the output driver
`ifndef P5M_CFG_SVH
`define P5M_CFG_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define P5M_CTRL_OFFSET 8'h15
`define P5M_STATUS_OFFSET 8'hF5
`define P5M_CTRL_RESET 8'h00
`define P5M_RDATA_RESET 8'h00

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define P5M_SEL_MSB 7
`define P5M_SEL_LSB 5
`define P5M_SRC_MSB 4
`define P5M_SRC_LSB 2
`define P5M_LEVEL_BIT 1
`define P5M_EN_BIT 0

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define P5M_ST_PIN_BIT 0
`define P5M_ST_OE_BIT 1
`define P5M_ST_RSVD_BIT 2

// ----------------------------------------------------------------
// source codes
// ----------------------------------------------------------------
`define P5M_SRC_STATUS 3'h4
`define P5M_SRC_RSVD_A 3'h5
`define P5M_SRC_TX 3'h6
`define P5M_SRC_RSVD_B 3'h7

// ----------------------------------------------------------------
// select codes, device status source
// ----------------------------------------------------------------
`define P5M_DEV_LEVEL 3'h0
`define P5M_DEV_LOCK_OR 3'h1
`define P5M_DEV_LOCK_AND 3'h2
`define P5M_DEV_PASS_AND 3'h3
`define P5M_DEV_FSYNC 3'h4

// ----------------------------------------------------------------
// select codes, transmit source
// ----------------------------------------------------------------
`define P5M_TX_PASS_AND 3'h0
`define P5M_TX_PASS_OR 3'h1
`define P5M_TX_FRAME 3'h2
`define P5M_TX_LINE 3'h3
`define P5M_TX_SYNCED 3'h4
`define P5M_TX_IRQ 3'h5

`endif

/* rtl/p5m_pkg.sv */
// types shared by the pin 5 output source multiplexer
package p5m_pkg;

    typedef logic [7:0] p5m_byte_t;
    typedef logic [2:0] p5m_code_t;
    typedef logic [3:0] p5m_port_vec_t;
    // forwarded remote pins: [port][pin]
    typedef logic [3:0][3:0] p5m_fwd_t;

    typedef struct packed {
        p5m_byte_t ctrl;
        p5m_byte_t rdata;
        logic pin_level;
        logic pin_oe;
    } p5m_state_t;

endpackage

/* rtl/p5m_top.sv */
// pin 5 output control register and output source multiplexer
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "p5m_cfg.svh"

module p5m_top (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // register port
    input wire p5m_pkg::p5m_byte_t reg_addr_i,
    input wire p5m_pkg::p5m_byte_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output var p5m_pkg::p5m_byte_t reg_rdata_o,
    // receive port status
    input wire p5m_pkg::p5m_fwd_t rx_fwd_pin_i,
    input wire p5m_pkg::p5m_port_vec_t rx_lock_i,
    input wire p5m_pkg::p5m_port_vec_t rx_pass_i,
    input wire p5m_pkg::p5m_port_vec_t rx_frame_valid_i,
    input wire p5m_pkg::p5m_port_vec_t rx_line_valid_i,
    input wire p5m_pkg::p5m_port_vec_t rx_port_en_i,
    input wire p5m_pkg::p5m_port_vec_t rx_port_fwd_sel_i,
    // device and transmit status
    input wire logic frame_sync_i,
    input wire logic tx_frame_active_i,
    input wire logic tx_line_active_i,
    input wire logic tx_synced_i,
    input wire logic tx_irq_i,
    // pin
    output var logic pin5_o,
    output var logic pin5_oe_o
);
    import p5m_pkg::*;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // an empty set of ports reads as low, so a pin watching an
    // unconfigured hub never claims everything is locked
    function automatic logic and_over(
        input p5m_port_vec_t vals,
        input p5m_port_vec_t mask
    );
        and_over = (|mask) & (&(vals | ~mask));
    endfunction

    function automatic logic or_over(
        input p5m_port_vec_t vals,
        input p5m_port_vec_t mask
    );
        or_over = |(vals & mask);
    endfunction

    function automatic logic is_rx_src(input p5m_code_t src);
        is_rx_src = (src[2] == 1'b0);
    endfunction

    // true when the source and select pair has no defined meaning
    function automatic logic is_reserved(
        input p5m_code_t src,
        input p5m_code_t sel
    );
        logic rsvd;
        rsvd = 1'b0;
        if (src == `P5M_SRC_RSVD_A || src == `P5M_SRC_RSVD_B) begin
            rsvd = 1'b1;
        end else if (src == `P5M_SRC_STATUS) begin
            rsvd = (sel > `P5M_DEV_FSYNC);
        end else if (src == `P5M_SRC_TX) begin
            rsvd = (sel > `P5M_TX_IRQ);
        end
        is_reserved = rsvd;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    p5m_state_t s_r;
    p5m_state_t s_nxt;

    // ----------------------------------------------------------------
    // per-port candidate signals
    // ----------------------------------------------------------------

    // index is the select code when a receive port is the source
    logic [3:0][7:0] port_cand;

    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_port
            assign port_cand[gp] = {
                rx_line_valid_i[gp],
                rx_frame_valid_i[gp],
                rx_pass_i[gp],
                rx_lock_i[gp],
                rx_fwd_pin_i[gp]
            };
        end
    endgenerate

    // ----------------------------------------------------------------
    // source multiplexer
    // ----------------------------------------------------------------
    p5m_byte_t ctrl_next;
    p5m_code_t src_code;
    p5m_code_t sel_code;
    logic rx_level;
    logic dev_level;
    logic tx_level;
    logic mux_level;
    logic drv_en;
    logic rsvd_sel;

    always_comb begin
        // the pin follows the control value written this cycle, so the
        // pin changes on the same edge that stores the write
        ctrl_next = s_r.ctrl;
        if (reg_wr_i && reg_addr_i == `P5M_CTRL_OFFSET) begin
            ctrl_next = reg_wdata_i;
        end
        src_code = ctrl_next[`P5M_SRC_MSB:`P5M_SRC_LSB];
        sel_code = ctrl_next[`P5M_SEL_MSB:`P5M_SEL_LSB];
        drv_en = ctrl_next[`P5M_EN_BIT];
        rsvd_sel = is_reserved(src_code, sel_code);

        rx_level = port_cand[src_code[1:0]][sel_code];

        case (sel_code)
            `P5M_DEV_LEVEL: begin
                dev_level = ctrl_next[`P5M_LEVEL_BIT];
            end
            `P5M_DEV_LOCK_OR: begin
                dev_level = or_over(rx_lock_i, rx_port_en_i);
            end
            `P5M_DEV_LOCK_AND: begin
                dev_level = and_over(rx_lock_i, rx_port_en_i);
            end
            `P5M_DEV_PASS_AND: begin
                dev_level = and_over(rx_pass_i, rx_port_en_i);
            end
            `P5M_DEV_FSYNC: begin
                dev_level = frame_sync_i;
            end
            default: begin
                dev_level = 1'b0;
            end
        endcase

        case (sel_code)
            `P5M_TX_PASS_AND: begin
                tx_level = and_over(rx_pass_i, rx_port_fwd_sel_i);
            end
            `P5M_TX_PASS_OR: begin
                tx_level = or_over(rx_pass_i, rx_port_fwd_sel_i);
            end
            `P5M_TX_FRAME: begin
                tx_level = tx_frame_active_i;
            end
            `P5M_TX_LINE: begin
                tx_level = tx_line_active_i;
            end
            `P5M_TX_SYNCED: begin
                tx_level = tx_synced_i;
            end
            `P5M_TX_IRQ: begin
                tx_level = tx_irq_i;
            end
            default: begin
                tx_level = 1'b0;
            end
        endcase

        if (is_rx_src(src_code)) begin
            mux_level = rx_level;
        end else if (src_code == `P5M_SRC_STATUS) begin
            mux_level = dev_level;
        end else if (src_code == `P5M_SRC_TX) begin
            mux_level = tx_level;
        end else begin
            mux_level = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (ce_i) begin
            s_nxt.ctrl = ctrl_next;
            // read data stand for one cycle only
            s_nxt.rdata = `P5M_RDATA_RESET;
            if (reg_rd_i) begin
                if (reg_addr_i == `P5M_CTRL_OFFSET) begin
                    s_nxt.rdata = s_r.ctrl;
                end else if (reg_addr_i == `P5M_STATUS_OFFSET) begin
                    s_nxt.rdata[`P5M_ST_PIN_BIT] = s_r.pin_level;
                    s_nxt.rdata[`P5M_ST_OE_BIT] = s_r.pin_oe;
                    s_nxt.rdata[`P5M_ST_RSVD_BIT] =
                        is_reserved(s_r.ctrl[`P5M_SRC_MSB:`P5M_SRC_LSB],
                                    s_r.ctrl[`P5M_SEL_MSB:`P5M_SEL_LSB]);
                end
            end
            // a disabled driver leaves the level low as well
            s_nxt.pin_oe = drv_en;
            s_nxt.pin_level = drv_en & ~rsvd_sel & mux_level;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r.ctrl <= `P5M_CTRL_RESET;
            s_r.rdata <= `P5M_RDATA_RESET;
            s_r.pin_level <= 1'b0;
            s_r.pin_oe <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = s_r.rdata;
    assign pin5_o = s_r.pin_level;
    assign pin5_oe_o = s_r.pin_oe;

endmodule // p5m_top

`default_nettype wire

/* bench/p5m_chk.sv */
// assertion checker for the pin 5 output source multiplexer
`timescale 1ns/10ps
`default_nettype none
module p5m_chk
    import p5m_pkg::*;
(
    // clock, reset, register port
    input wire logic clk_i, resetn_i, ce_i, reg_wr_i, reg_rd_i,
    input wire p5m_byte_t reg_addr_i, reg_wdata_i, reg_rdata_o,
    // status inputs
    input wire p5m_fwd_t rx_fwd_pin_i,
    input wire p5m_port_vec_t rx_lock_i, rx_pass_i, rx_frame_valid_i, rx_line_valid_i,
    input wire p5m_port_vec_t rx_port_en_i, rx_port_fwd_sel_i,
    input wire logic frame_sync_i, tx_frame_active_i, tx_line_active_i, tx_synced_i, tx_irq_i,
    // pin
    input wire logic pin5_o, pin5_oe_o
);
    // ----------------------------------------------------------------
    // shadow of the control byte, as it stands after each edge
    // ----------------------------------------------------------------
    p5m_byte_t sh_r, sh_nxt, pv, dv, tv;
    logic wr15, exp_w;
    p5m_code_t src_w, sel_w;
    p5m_port_vec_t en, fs;
    assign wr15 = ce_i && reg_wr_i && reg_addr_i == 8'h15;
    assign sh_nxt = wr15 ? reg_wdata_i : sh_r;
    assign src_w = sh_nxt[4:2];
    assign sel_w = sh_nxt[7:5];
    assign en = rx_port_en_i;
    assign fs = rx_port_fwd_sel_i;
    assign pv = {rx_line_valid_i[src_w[1:0]], rx_frame_valid_i[src_w[1:0]],
        rx_pass_i[src_w[1:0]], rx_lock_i[src_w[1:0]], rx_fwd_pin_i[src_w[1:0]]};
    // an empty mask reads as low for AND and OR alike
    assign dv = {3'h0, frame_sync_i, (en != 4'h0) && ((rx_pass_i & en) == en),
        (en != 4'h0) && ((rx_lock_i & en) == en), |(rx_lock_i & en), sh_nxt[1]};
    assign tv = {2'h0, tx_irq_i, tx_synced_i, tx_line_active_i, tx_frame_active_i,
        |(rx_pass_i & fs), (fs != 4'h0) && ((rx_pass_i & fs) == fs)};
    assign exp_w = sh_nxt[0] & (!src_w[2] ? pv[sel_w] : src_w == 3'h4 ? dv[sel_w] :
        src_w == 3'h6 ? tv[sel_w] : 1'b0);
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) sh_r <= 8'h00;
        else sh_r <= sh_nxt;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_rx_pin; ce_i && !src_w[2] && !sel_w[2] |=> pin5_o == $past(exp_w); endproperty
    a_rx_pin: assert property (p_rx_pin) else $error("rx pin select wrong");
    property p_rx_st; ce_i && !src_w[2] && sel_w[2] |=> pin5_o == $past(exp_w); endproperty
    a_rx_st: assert property (p_rx_st) else $error("rx status select wrong");
    property p_dev; ce_i && src_w == 3'h4 |=> pin5_o == $past(exp_w); endproperty
    a_dev: assert property (p_dev) else $error("device status wrong");
    property p_tx; ce_i && src_w == 3'h6 |=> pin5_o == $past(exp_w); endproperty
    a_tx: assert property (p_tx) else $error("transmit status wrong");
    property p_rsvd; ce_i && src_w[2] && src_w[0] |=> !pin5_o; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved source not low");
    property p_oe; wr15 |=> pin5_oe_o == $past(reg_wdata_i[0]); endproperty
    a_oe: assert property (p_oe) else $error("driver enable wrong");
    property p_off; !pin5_oe_o |-> !pin5_o; endproperty
    a_off: assert property (p_off) else $error("pin high while disabled");
    property p_rd; ce_i && reg_rd_i && reg_addr_i == 8'h15 |=> reg_rdata_o == $past(sh_r);
    endproperty
    a_rd: assert property (p_rd) else $error("control read wrong");
    property p_idle; ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not cleared");
    property p_hold; !ce_i |=> $stable(pin5_o) && $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("state moved without enable");
endmodule // p5m_chk
bind p5m_top p5m_chk u_p5m_chk (.clk_i, .resetn_i, .ce_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .rx_fwd_pin_i, .rx_lock_i, .rx_pass_i, .rx_frame_valid_i,
    .rx_line_valid_i, .rx_port_en_i, .rx_port_fwd_sel_i, .frame_sync_i, .tx_frame_active_i,
    .tx_line_active_i, .tx_synced_i, .tx_irq_i, .pin5_o, .pin5_oe_o);
`default_nettype wire

/* bench/p5m_pin_model.sv */
// model of the circuitry hanging on pin 5
`timescale 1ns/10ps
`default_nettype none
module p5m_pin_model (
    input wire logic clk_i,
    input wire logic pin5_i,
    input wire logic pin5_oe_i,
    output var logic wire_o
);
    logic last_r = 1'b0;
    always_ff @(posedge clk_i) begin
        if (pin5_oe_i) last_r <= pin5_i;
    end
    // no pull on the net: an undriven pin must not look like the last value
    assign wire_o = pin5_oe_i ? pin5_i : ~last_r;
endmodule // p5m_pin_model
`default_nettype wire

/* bench/tb_top.sv */
// register-level testbench for the pin 5 output source multiplexer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
    import p5m_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    p5m_byte_t reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    p5m_fwd_t rx_fwd_pin_i = 16'hA5C3;
    p5m_port_vec_t rx_lock_i = 4'h5, rx_pass_i = 4'hA, rx_frame_valid_i = 4'h3;
    p5m_port_vec_t rx_line_valid_i = 4'hC, rx_port_en_i = 4'h5, rx_port_fwd_sel_i = 4'hA;
    logic frame_sync_i = 1'b1, tx_frame_active_i = 1'b1, tx_line_active_i = 1'b0;
    logic tx_synced_i = 1'b1, tx_irq_i = 1'b1, pin5_o, pin5_oe_o, pin_wire;
    int failures = 0, n_checks = 0;
    p5m_top u_p5m_top (.clk_i, .resetn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .rx_fwd_pin_i, .rx_lock_i, .rx_pass_i, .rx_frame_valid_i,
        .rx_line_valid_i, .rx_port_en_i, .rx_port_fwd_sel_i, .frame_sync_i,
        .tx_frame_active_i, .tx_line_active_i, .tx_synced_i, .tx_irq_i, .pin5_o, .pin5_oe_o);
    p5m_pin_model u_p5m_pin_model (.clk_i, .pin5_i(pin5_o), .pin5_oe_i(pin5_oe_o),
        .wire_o(pin_wire));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // ----------------------------------------------------------------
    // bus tasks and expected pin level
    // ----------------------------------------------------------------
    task automatic wr(input p5m_byte_t a, input p5m_byte_t d);
        @(posedge clk_i) begin reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1; end
        @(posedge clk_i) reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input p5m_byte_t a, input p5m_byte_t e);
        @(posedge clk_i) begin reg_addr_i <= a; reg_rd_i <= 1'b1; end
        @(posedge clk_i) reg_rd_i <= 1'b0;
        #1 `CHK(reg_rdata_o, e)
    endtask
    // status and transmit rows hold for the fixed stimulus with level bit set
    function automatic logic exp_f(int s, int o);
        p5m_byte_t v;
        v = (s < 4) ? {rx_line_valid_i[s], rx_frame_valid_i[s], rx_pass_i[s], rx_lock_i[s],
            rx_fwd_pin_i[s]} : (s == 4) ? 8'h17 : (s == 6) ? 8'h37 : 8'h00;
        return v[o];
    endfunction
    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(8'h15, 8'h00);
        rd(8'h33, 8'h00);
        `CHK(pin5_oe_o, 1'b0)
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            for (int o = 0; o < 8; o++) begin
                wr(8'h15, {o[2:0], s[2:0], 2'b11});
                #1 `CHK(pin5_o, exp_f(s, o))
                `CHK(pin_wire, exp_f(s, o))
            end
        end
        rd(8'h15, 8'hFF);
        $display("test mux done");
        wr(8'h15, 8'h13);
        rd(8'hF5, 8'h03);
        wr(8'hF5, 8'hFF);
        rd(8'h15, 8'h13);
        wr(8'h15, 8'h12);
        #1 `CHK(pin5_o, 1'b0)
        `CHK(pin5_oe_o, 1'b0)
        @(posedge clk_i) ce_i <= 1'b0;
        wr(8'h15, 8'hFF);
        @(posedge clk_i) ce_i <= 1'b1;
        rd(8'h15, 8'h12);
        $display("test enable done");
        @(posedge clk_i) rx_port_en_i <= 4'h0;
        wr(8'h15, 8'h51);
        #1 `CHK(pin5_o, 1'b0)
        wr(8'h15, 8'h31);
        #1 `CHK(pin5_o, 1'b0)
        $display("test empty mask done");
        results;
    end
    initial begin
        #20000;
        failures++;
        results;
    end
endmodule // tb_top
`default_nettype wire
